// ==== rtl/can_filter_defines.svh ====
// Purpose: offsets, field positions and reset values of the acceptance filter block
// Assumes: APB byte addresses, one 32-bit word per 16-bit register
// Notes: included by bare name
//
// Operation
// - a hit stores the message by the filter's 4-bit pointer, 1111 the FIFO, 0000-1110 buffer 0-14.
// - four pointers share a 16-bit register, lowest filter in bits 3-0, highest in bits 15-12.
// - each filter keeps an 11-bit standard identifier in bits 15-5 that compared bits must equal.
// - each filter keeps an 18-bit extended identifier, bits 17-16 in bits 1-0, 15-0 apart.
// - with frame type enforced, a set type bit accepts only extended and clear only standard frames.
// - with frame type not enforced, the filter's type bit is ignored.
// - a 2-bit source picks mask 0, 1 or 2; software never writes code 11.
// - the sources of filters 0-7 share one register, filter 0 in bits 1-0 up to filter 7 in 15-14.
// - bits 4 and 2 of the identifier register read zero; ids reset unknown, pointers and sources zero.
// - a set mask bit takes part in the compare and a clear one is a don't-care.
// - without enforcement a frame matches on its standard id or on its full id.
`ifndef CAN_FILTER_DEFINES_SVH
`define CAN_FILTER_DEFINES_SVH

// word indices (byte address = index * 4)
`define CAF_IDX_POINTER 6'd0
`define CAF_IDX_MASK_SELECT 6'd4
`define CAF_IDX_MASK 6'd6
`define CAF_IDX_STATUS 6'd12
`define CAF_IDX_FILTER 6'd16
`define CAF_NUM_POINTER_REGS 6'd4
`define CAF_NUM_MASK_SELECT_REGS 6'd2
`define CAF_NUM_MASK_REGS 6'd6
`define CAF_NUM_FILTER_REGS 6'd32

// identifier register fields
`define CAF_SID_MSB 15
`define CAF_SID_LSB 5
`define CAF_FRAME_TYPE_BIT 3
`define CAF_EID_HIGH_MSB 1
`define CAF_SID_REG_WRITABLE 16'hffeb

// codes
`define CAF_POINTER_FIFO 4'hf
`define CAF_MASK_SOURCE_RESERVED 2'h3
`define CAF_REG_RESET 16'h0000

`endif

// ==== rtl/can_filter_pkg.sv ====
// Purpose: types shared by the acceptance filter block
// Assumes: identifier layout of CAN 2.0B
// Notes: none
package can_filter_pkg;

    typedef struct packed {
        logic ide;
        logic [10:0] standard_identifier;
        logic [17:0] extended_identifier;
    } rx_id_s;

    typedef struct packed {
        logic valid;
        logic [3:0] filterNum;
        logic toFifo;
        logic [3:0] bufferNum;
    } hit_s;

    typedef struct packed {
        logic [3:0][15:0] pointerRegs;
        logic [1:0][15:0] maskSelect;
        logic [5:0][15:0] maskRegs;
        hit_s lastHit;
        logic hitPulse;
        logic missPulse;
        logic ack;
        logic slvErr;
        logic [15:0] rdata;
    } state_s;

endpackage

// ==== rtl/filter_id_table.sv ====
// Purpose: identifier words of all filters, two words per filter
// Assumes: writes already cleaned of unimplemented bits
// Notes: contents are not reset; whole table is visible for parallel matching
`timescale 1ns/1ps
module filter_id_table #(
    parameter int DEPTH = 32,
    parameter int WIDTH = 16,
    parameter int AW = 5
)(
    input wire logic clk,
    input wire logic [1:0] writeLanes,
    input wire logic [AW-1:0] writeAddr,
    input wire logic [WIDTH-1:0] writeData,
    input wire logic [AW-1:0] readAddr,
    output logic [WIDTH-1:0] readData,
    output logic [DEPTH*WIDTH-1:0] allWords
);
    logic [DEPTH-1:0][WIDTH-1:0] mem;

    // byte lanes write independently
    always_ff @(posedge clk)
    begin
        if (writeLanes[0])
        begin
            mem[writeAddr][7:0] <= writeData[7:0];
        end
        if (writeLanes[1])
        begin
            mem[writeAddr][WIDTH-1:8] <= writeData[WIDTH-1:8];
        end
        readData <= mem[readAddr];
    end

    assign allWords = mem;
endmodule // filter_id_table

// ==== rtl/can_acceptance_filter_config.sv ====
// Purpose: sixteen CAN acceptance filters with APB set-up and a hit result
// Assumes: received identifier arrives from the protocol engine on clk
// Notes: one wait state on every APB access
//
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/1ps
`include "can_filter_defines.svh"
module can_acceptance_filter_config
    import can_filter_pkg::*;
#(
    parameter int ADDR_W = 12,
    parameter int NUM_FILTERS = 16
)(
    input wire logic clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire rx_id_s rxId,
    input wire logic rxIdValid,
    output hit_s hitInfo,
    output logic rxMiss
);
    typedef enum logic [2:0] {
        REG_POINTER = 3'b000,
        REG_MASK_SELECT = 3'b001,
        REG_MASK = 3'b010,
        REG_STATUS = 3'b011,
        REG_FILTER = 3'b100,
        REG_NONE = 3'b101
    } region_e;

    state_s state;
    state_s next_state;
    logic [5:0] wordIdx;
    region_e region;
    logic [4:0] tableWord;
    logic [15:0] tableRead;
    logic [NUM_FILTERS*32-1:0] tableAll;
    logic [1:0] tableLanes;
    logic [15:0] tableData;
    logic writeNow;

    // -----------------------------------------------------------------
    // helpers
    // -----------------------------------------------------------------
    function automatic region_e regionOf(input logic [ADDR_W-1:0] a);
        logic [5:0] w;
        w = a[7:2];
        if (a[1:0] != 2'b00 || a[ADDR_W-1:8] != '0)
        begin
            return REG_NONE;
        end
        if (w < `CAF_IDX_POINTER + `CAF_NUM_POINTER_REGS)
        begin
            return REG_POINTER;
        end
        if (w >= `CAF_IDX_MASK_SELECT && w < `CAF_IDX_MASK_SELECT + `CAF_NUM_MASK_SELECT_REGS)
        begin
            return REG_MASK_SELECT;
        end
        if (w >= `CAF_IDX_MASK && w < `CAF_IDX_MASK + `CAF_NUM_MASK_REGS)
        begin
            return REG_MASK;
        end
        if (w == `CAF_IDX_STATUS)
        begin
            return REG_STATUS;
        end
        if (w >= `CAF_IDX_FILTER && w < `CAF_IDX_FILTER + `CAF_NUM_FILTER_REGS)
        begin
            return REG_FILTER;
        end
        return REG_NONE;
    endfunction

    function automatic logic [15:0] mergeLanes(input logic [15:0] old,
                                               input logic [15:0] data,
                                               input logic [1:0] lanes);
        mergeLanes = old;
        if (lanes[0])
        begin
            mergeLanes[7:0] = data[7:0];
        end
        if (lanes[1])
        begin
            mergeLanes[15:8] = data[15:8];
        end
    endfunction

    // one filter against one received identifier
    function automatic logic filterMatch(input logic [15:0] fSidReg,
                                         input logic [15:0] fEidReg,
                                         input logic [15:0] mSidReg,
                                         input logic [15:0] mEidReg,
                                         input rx_id_s id);
        logic sidOk;
        logic eidOk;
        logic enforce;
        logic wantExt;
        sidOk = ((id.standard_identifier ^ fSidReg[`CAF_SID_MSB:`CAF_SID_LSB])
                 & mSidReg[`CAF_SID_MSB:`CAF_SID_LSB]) == 11'h000;
        eidOk = ((id.extended_identifier ^ {fSidReg[`CAF_EID_HIGH_MSB:0], fEidReg})
                 & {mSidReg[`CAF_EID_HIGH_MSB:0], mEidReg}) == 18'h00000;
        enforce = mSidReg[`CAF_FRAME_TYPE_BIT];
        wantExt = fSidReg[`CAF_FRAME_TYPE_BIT];
        if (enforce)
        begin
            filterMatch = (wantExt == id.ide) && sidOk && (!wantExt || eidOk);
        end
        else
        begin
            // sid match alone or sid plus eid match: either is enough
            filterMatch = sidOk;
        end
    endfunction

    // -----------------------------------------------------------------
    // identifier table
    // -----------------------------------------------------------------
    assign wordIdx = paddr[7:2];
    assign region = regionOf(paddr);
    assign tableWord = 5'(wordIdx - `CAF_IDX_FILTER);
    assign writeNow = psel && penable && pwrite && state.ack;
    assign tableLanes = (writeNow && region == REG_FILTER) ? pstrb[1:0] : 2'b00;
    // even words hold the standard id; bits 4 and 2 never stored
    assign tableData = tableWord[0] ? pwdata[15:0]
                                    : (pwdata[15:0] & `CAF_SID_REG_WRITABLE);

    filter_id_table #(
        .DEPTH(NUM_FILTERS * 2),
        .WIDTH(16),
        .AW(5)
    ) idTable (
        .clk(clk),
        .writeLanes(tableLanes),
        .writeAddr(tableWord),
        .writeData(tableData),
        .readAddr(tableWord),
        .readData(tableRead),
        .allWords(tableAll)
    );

    // -----------------------------------------------------------------
    // next state
    // -----------------------------------------------------------------
    always_comb
    begin
        logic [15:0] localRead;
        logic [5:0] sub;
        logic found;
        logic [3:0] foundNum;
        logic [1:0] src;
        logic [3:0] ptr;
        localRead = 16'h0000;
        sub = 6'd0;
        found = 1'b0;
        foundNum = 4'h0;
        src = 2'b00;
        ptr = 4'h0;
        next_state = state;
        next_state.hitPulse = 1'b0;
        next_state.missPulse = 1'b0;

        // register bus
        unique case (region)
            REG_POINTER:
            begin
                sub = wordIdx - `CAF_IDX_POINTER;
                localRead = state.pointerRegs[sub[1:0]];
            end
            REG_MASK_SELECT:
            begin
                sub = wordIdx - `CAF_IDX_MASK_SELECT;
                localRead = state.maskSelect[sub[0]];
            end
            REG_MASK:
            begin
                sub = wordIdx - `CAF_IDX_MASK;
                localRead = state.maskRegs[sub[2:0]];
            end
            REG_STATUS:
            begin
                localRead = {state.lastHit.valid, 3'b000, state.lastHit.filterNum,
                             state.lastHit.bufferNum, 3'b000, state.lastHit.toFifo};
            end
            REG_FILTER:
            begin
                localRead = 16'h0000;
            end
            default:
            begin
                localRead = 16'h0000;
            end
        endcase

        if (psel && penable && !state.ack)
        begin
            next_state.ack = 1'b1;
            next_state.slvErr = (region == REG_NONE);
            next_state.rdata = (region == REG_FILTER) ? tableRead : localRead;
        end
        else if (psel && penable && state.ack)
        begin
            next_state.ack = 1'b0;
        end

        if (writeNow)
        begin
            unique case (region)
                REG_POINTER:
                begin
                    next_state.pointerRegs[sub[1:0]] = mergeLanes(
                        state.pointerRegs[sub[1:0]], pwdata[15:0], pstrb[1:0]);
                end
                REG_MASK_SELECT:
                begin
                    next_state.maskSelect[sub[0]] = mergeLanes(
                        state.maskSelect[sub[0]], pwdata[15:0], pstrb[1:0]);
                end
                REG_MASK:
                begin
                    // even mask words share the identifier layout
                    next_state.maskRegs[sub[2:0]] = mergeLanes(
                        state.maskRegs[sub[2:0]],
                        sub[0] ? pwdata[15:0] : (pwdata[15:0] & `CAF_SID_REG_WRITABLE),
                        pstrb[1:0]);
                end
                default:
                begin
                end
            endcase
        end

        // matching: lowest-numbered hitting filter wins
        if (rxIdValid)
        begin
            for (int f = NUM_FILTERS - 1; f >= 0; f--)
            begin
                src = state.maskSelect[f / 8][(f % 8) * 2 +: 2];
                if (src != `CAF_MASK_SOURCE_RESERVED
                    && filterMatch(tableAll[f * 32 +: 16], tableAll[f * 32 + 16 +: 16],
                                   state.maskRegs[src * 2], state.maskRegs[src * 2 + 1],
                                   rxId))
                begin
                    found = 1'b1;
                    foundNum = 4'(f);
                end
            end
            ptr = state.pointerRegs[foundNum[3:2]][foundNum[1:0] * 4 +: 4];
            if (found)
            begin
                next_state.hitPulse = 1'b1;
                next_state.lastHit.valid = 1'b1;
                next_state.lastHit.filterNum = foundNum;
                next_state.lastHit.toFifo = (ptr == `CAF_POINTER_FIFO);
                next_state.lastHit.bufferNum = ptr;
            end
            else
            begin
                next_state.missPulse = 1'b1;
            end
        end
    end

    // -----------------------------------------------------------------
    // state register
    // -----------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state.pointerRegs <= {4{`CAF_REG_RESET}};
            state.maskSelect <= {2{`CAF_REG_RESET}};
            state.maskRegs <= {6{`CAF_REG_RESET}};
            state.lastHit <= '0;
            state.hitPulse <= 1'b0;
            state.missPulse <= 1'b0;
            state.ack <= 1'b0;
            state.slvErr <= 1'b0;
            state.rdata <= 16'h0000;
        end
        else
        begin
            state <= next_state;
        end
    end

    // -----------------------------------------------------------------
    // outputs
    // -----------------------------------------------------------------
    assign pready = state.ack;
    assign pslverr = state.ack && state.slvErr;
    assign prdata = {16'h0000, state.rdata};
    assign hitInfo = '{valid: state.hitPulse,
                       filterNum: state.lastHit.filterNum,
                       toFifo: state.lastHit.toFifo,
                       bufferNum: state.lastHit.bufferNum};
    assign rxMiss = state.missPulse;
endmodule // can_acceptance_filter_config

// ==== bench/can_acceptance_filter_config_properties.sv ====
// Purpose: port checks of the acceptance filter block
// Assumes: one wait state on APB, hit answer one cycle after a frame
// Notes: bound to the top module below
`timescale 1ns/1ps
module can_acceptance_filter_config_properties
    import can_filter_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic rxIdValid,
    input wire hit_s hitInfo,
    input wire logic rxMiss
);
    // ----
    // properties
    // ----
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence setupS;
        psel && !penable;
    endsequence
    sequence accessS;
        psel && penable;
    endsequence
    AST_READY_WAIT: assert property (setupS ##1 accessS |-> !pready ##1 pready)
        else $error("pready not in second access cycle");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    AST_ERR_READY: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    AST_SID_GAPS: assert property (pready && !pwrite && paddr[7:6] != 2'b00
        && paddr[7:6] != 2'b11 && !paddr[2] |-> prdata[4] == 1'b0 && prdata[2] == 1'b0)
        else $error("unimplemented identifier bits read nonzero");
    AST_ANSWER: assert property (rxIdValid |=> hitInfo.valid ^ rxMiss)
        else $error("frame without single answer");
    AST_QUIET: assert property (!rxIdValid |=> !hitInfo.valid && !rxMiss)
        else $error("answer without frame");
    AST_FIFO: assert property (hitInfo.valid |-> hitInfo.toFifo == &hitInfo.bufferNum)
        else $error("fifo flag disagrees with pointer");
    AST_HOLD: assert property (!hitInfo.valid |-> $stable(hitInfo[8:0]))
        else $error("hit fields moved without a hit");
endmodule // can_acceptance_filter_config_properties

bind can_acceptance_filter_config can_acceptance_filter_config_properties props_inst (
    .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .rxIdValid(rxIdValid), .hitInfo(hitInfo), .rxMiss(rxMiss));

// ==== bench/can_frame_source.sv ====
// Purpose: remote node handing received identifiers to the block
// Assumes: one frame per call, valid for one cycle
// Notes: released identifier shows the inverse, never the last value
`timescale 1ns/1ps
module can_frame_source
    import can_filter_pkg::*;
(
    input wire logic clk,
    output rx_id_s rxId,
    output logic rxIdValid
);
    initial
    begin
        rxId = '0;
        rxIdValid = 1'b0;
    end
    task automatic send(input rx_id_s id);
        @(posedge clk);
        rxIdValid <= 1'b1;
        rxId <= id;
        @(posedge clk);
        rxIdValid <= 1'b0;
        rxId <= ~id;
    endtask
endmodule // can_frame_source

// ==== bench/can_acceptance_filter_config_tb.sv ====
// Purpose: self-checking bench of the acceptance filter block
// Assumes: APB master tasks, register mirror in regs
// Notes: frames are built near stored filters so hits occur
`timescale 1ns/1ps
module can_acceptance_filter_config_tb
    import can_filter_pkg::*;
;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'h0;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic rxIdValid;
    rx_id_s rxId;
    hit_s hitInfo;
    logic rxMiss;
    logic [15:0] regs [0:63];
    logic [8:0] lastF = 9'h0;
    int error_cnt = 0;
    int samples_checked = 0;
    always #10 clk = ~clk;
    can_acceptance_filter_config can_acceptance_filter_config_inst (.clk(clk),
        .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .rxId(rxId), .rxIdValid(rxIdValid), .hitInfo(hitInfo),
        .rxMiss(rxMiss));
    can_frame_source can_frame_source_inst (.clk(clk), .rxId(rxId), .rxIdValid(rxIdValid));
    // ----
    // tasks
    // ----
    task automatic end_sim();
        if (error_cnt == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [15:0] d,
        input logic [3:0] s, output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {4'h0, a};
        pwdata <= {16'h0, d};
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 20)
        begin
            @(posedge clk);
            n++;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 20)
        begin
            error_cnt++;
            end_sim();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s);
        logic [31:0] rd;
        logic err;
        apb(1'b1, a, d, s, rd, err);
        if (s[0]) regs[a[7:2]][7:0] = d[7:0];
        if (s[1]) regs[a[7:2]][15:8] = d[15:8];
        if (a[7:2] > 5 && !a[2]) regs[a[7:2]] &= 16'hffeb;
    endtask
    task automatic rdchk(input logic [7:0] a);
        logic [31:0] rd;
        logic err;
        apb(1'b0, a, 16'h0, 4'h0, rd, err);
        chk("prdata", {16'h0, regs[a[7:2]]}, rd);
        chk("pslverr", 32'h0, {31'h0, err});
    endtask
    function automatic logic [4:0] predict(input rx_id_s id);
        logic [15:0] ms, fs;
        logic [1:0] m;
        logic so, eo;
        for (int f = 0; f < 16; f++)
        begin
            m = regs[4 + f / 8][2 * (f % 8) +: 2];
            ms = regs[6 + 2 * m];
            fs = regs[16 + 2 * f];
            so = ((id.standard_identifier ^ fs[15:5]) & ms[15:5]) == 11'h0;
            eo = ((id.extended_identifier ^ {fs[1:0], regs[17 + 2 * f]})
                  & {ms[1:0], regs[7 + 2 * m]}) == 18'h0;
            if (m != 2'h3 && (ms[3] ? id.ide == fs[3] && so && (!id.ide || eo) : so))
                return {1'b1, 4'(f)};
        end
        return 5'h0;
    endfunction
    // ----
    // main sequence
    // ----
    initial
    begin
        logic [31:0] rd, sel;
        logic err;
        logic [4:0] p;
        logic [3:0] bp;
        logic [7:0] bad [3];
        rx_id_s id;
        int f;
        void'($urandom(33332));
        bad = '{8'h38, 8'h41, 8'hc0};
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        for (int i = 0; i < 13; i++) regs[i] = 16'h0;
        for (int i = 0; i < 13; i++) rdchk(8'(4 * i));
        foreach (bad[i])
        begin
            apb(1'b0, bad[i], 16'h0, 4'h0, rd, err);
            chk("unmapped", 32'h1, {31'h0, err});
            chk("unmapped data", 32'h0, rd);
        end
        for (int i = 0; i < 48; i++)
            if (i < 12 && i != 4 && i != 5 || i >= 16) wr(8'(4 * i), 16'($urandom), 4'h3);
        for (int j = 0; j < 16; j++) sel[2 * j +: 2] = 2'($urandom % 3);
        sel[5:0] = 6'b100100;
        wr(8'h10, sel[15:0], 4'h3);
        wr(8'h14, sel[31:16], 4'h3);
        wr(8'h08, 16'hfe01, 4'h3);
        wr(8'h0c, 16'h5aa5, 4'h2);
        for (int i = 0; i < 48; i++)
            if (i < 12 || i >= 16) rdchk(8'(4 * i));
        for (int k = 0; k < 300; k++)
        begin
            f = $urandom % 16;
            id.standard_identifier = regs[16 + 2 * f][15:5] ^ (k % 3 == 0 ? 11'($urandom) : 11'h0);
            id.extended_identifier = {regs[16 + 2 * f][1:0], regs[17 + 2 * f]}
                     ^ (k % 5 == 0 ? 18'($urandom) : 18'h0);
            id.ide = 1'($urandom);
            p = predict(id);
            bp = regs[p[3:0] / 4][4 * (p[3:0] % 4) +: 4];
            if (p[4]) lastF = {p[3:0], bp == 4'hf, bp};
            if (p[4]) regs[12] = {1'b1, 3'h0, p[3:0], bp, 3'h0, bp == 4'hf};
            can_frame_source_inst.send(id);
            #1;
            chk("rx", {21'h0, !p[4], p[4], lastF}, {21'h0, rxMiss, hitInfo});
        end
        rdchk(8'h30);
        @(posedge clk);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        regs[2] = 16'h0;
        regs[12] = 16'h0;
        rdchk(8'h08);
        rdchk(8'h30);
        end_sim();
    end
endmodule // can_acceptance_filter_config_tb
